// [sid_id_map.sv]
// Top: read-only identification page served over APB
// Operation
// - Extended identifier bits 1-0 give full-power class 1.5/2.5/3.5/4.5 W.
// - Bit 3 flags transmit clock recovery, bit 2 receive clock recovery.
// - Bit 4 flags stored catalogue code; bit 5 reserved, reads zero.
// - Connector byte always present, using defined, vendor or unknown codes.
// - Eight compliance bytes carry at least one set indicator bit.
// - Encoding byte always holds the line encoding code.
// - Rate given in 100 Mb/s and 250 Mb/s steps in two bytes.
// - Zero means unspecified; above 25.4 Gb/s first byte reads FFh.
// - Rate-select tag byte: bit 0 version 1, bits 7-1 reserved zero.
// - Single-mode reach in km; zero means unsupported or technology derived.
// - Extended-bandwidth multimode reach in 2 metre steps; zero unsupported.
// - Standard multimode reaches in 1 metre steps; zero unsupported.
// - Cable assemblies report zero in all four fibre length bytes.
// - Combined length: 2 m steps for 850 nm laser, else 1 m cable.
// - Cable shorter than one metre reports one, never zero; a 0 m cable reach reads zero here.
// - Zero if not cable or derived; 255 beyond 508 m or 254 m.
// - Technology low nibble: wavelength control, cooled, avalanche, tuneable.
// - Technology high nibble encodes transmitter kind; 1010b up means copper.
// - Vendor name 16 ASCII, space padded; name or company id valid.
// - Interconnect rate byte flags five generations in bits 4-0.
// - Vendor company id is three bytes; all zero means unspecified.
// - Part number 16 ASCII bytes, space padded; zero means unspecified.
// - Bytes 128-255 show this page only while page select holds 00h.
//
// The APB slave port was decided locally.
`timescale 1ns/1ps
module sid_id_map #(
    parameter logic [1:0] POWER_CLASS = 2'b00,
    parameter bit TX_CDR = 1'b0,
    parameter bit RX_CDR = 1'b0,
    parameter bit CATALOG_PRESENT = 1'b0,
    parameter logic [7:0] CONNECTOR = 8'h07,
    parameter logic [63:0] COMPLIANCE = 64'h0000_0000_0000_0001,
    parameter logic [7:0] ENCODING = 8'h00,
    parameter int RATE_MBPS = 10300,
    parameter logic [7:0] RATE_SEL_TAGS = 8'h01,
    parameter int SM_REACH_KM = 0,
    parameter int OM3_REACH_M = 300,
    parameter int OM2_REACH_M = 0,
    parameter int OM1_REACH_M = 0,
    parameter int COMBINED_REACH_M = 400,
    parameter logic [3:0] TX_TECH = 4'h0,
    parameter logic [3:0] TECH_FLAGS = 4'h0,
    // Arbitrary text and identifier, not a real vendor
    parameter logic [127:0] VENDOR_NAME = "GENERIC VENDOR  ",
    parameter logic [23:0] VENDOR_CID = 24'h00_0000,
    parameter logic [127:0] VENDOR_PART = "PART-0001       ",
    parameter logic [7:0] RATE_GEN_FLAGS = 8'h01
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    initial begin
        if (RATE_MBPS < 0 || SM_REACH_KM > 255 || OM3_REACH_M < 0 || OM2_REACH_M < 0)
            $error("sid_id_map: bad reach or rate");
        if (VENDOR_NAME == 128'h0 && VENDOR_CID == 24'h0)
            $error("sid_id_map: name or company id must be valid");
        if (COMPLIANCE == 64'h0)
            $error("sid_id_map: compliance field empty");
    end

    // Derived fixed bytes
    localparam bit IS_CABLE = (TX_TECH >= sid_pkg::TECH_COPPER_LO);
    localparam bit IS_VCSEL = (TX_TECH == sid_pkg::TECH_VCSEL850);
    localparam int RATE_100 = RATE_MBPS / 100;
    localparam int RATE_250 = RATE_MBPS / 250;
    localparam logic [7:0] RATE100_B =
        (RATE_MBPS > 25400) ? sid_pkg::RATE_ESCAPE : 8'(RATE_100);
    localparam logic [7:0] RATE250_B = (RATE_250 > 255) ? 8'hff : 8'(RATE_250);
    localparam logic [7:0] EXT_ID_B = 8'({CATALOG_PRESENT, TX_CDR, RX_CDR, POWER_CLASS})
        & sid_pkg::EXT_ID_MASK;

    logic [7:0] om3_b;
    logic [7:0] om2_b;
    logic [7:0] om1_b;
    logic [7:0] comb_b;
    logic [7:0] sm_b;

    sid_field_fmt #(.STEP_M(2), .MAX_M(510), .FLOOR_ONE(1'b0)) u_om3 (
        .reach_m(16'(OM3_REACH_M)),
        .is_cable(IS_CABLE),
        .code(om3_b)
    );
    sid_field_fmt #(.STEP_M(1), .MAX_M(255), .FLOOR_ONE(1'b0)) u_om2 (
        .reach_m(16'(OM2_REACH_M)),
        .is_cable(IS_CABLE),
        .code(om2_b)
    );
    sid_field_fmt #(.STEP_M(1), .MAX_M(255), .FLOOR_ONE(1'b0)) u_om1 (
        .reach_m(16'(OM1_REACH_M)),
        .is_cable(IS_CABLE),
        .code(om1_b)
    );
    sid_field_fmt #(.STEP_M(1), .MAX_M(255), .FLOOR_ONE(1'b0)) u_sm (
        .reach_m(16'(SM_REACH_KM)),
        .is_cable(IS_CABLE),
        .code(sm_b)
    );
    // Combined byte: VCSEL 2 m steps to 508 m, cable 1 m steps to 254 m
    sid_field_fmt #(
        .STEP_M(IS_VCSEL ? 2 : 1),
        .MAX_M(IS_VCSEL ? sid_pkg::VCSEL_MAX_M : sid_pkg::CABLE_MAX_M),
        .FLOOR_ONE(IS_CABLE)
    ) u_comb (
        .reach_m((IS_VCSEL || IS_CABLE) ? 16'(COMBINED_REACH_M) : 16'h0000),
        .is_cable(1'b0),
        .code(comb_b)
    );

    typedef struct packed {
        logic [7:0] page;
        logic [31:0] rdata;
        logic ready;
        logic err;
    } sid_state_s;

    sid_state_s st_ff;
    sid_state_s nxt_st;

    logic [7:0] byte_idx;
    logic in_span;
    logic [7:0] rd_byte;
    logic [3:0] off;

    assign byte_idx = paddr[9:2];
    assign in_span = (paddr < sid_pkg::APB_SPAN) && (paddr[1:0] == 2'b00);

    // Byte lookup; only page 00h is held here, other pages read zero
    always_comb begin
        off = 4'h0;
        rd_byte = 8'h00;
        if (byte_idx == sid_pkg::PAGE_SEL_ADDR) begin
            rd_byte = st_ff.page;
        end else if (byte_idx >= sid_pkg::UPPER_BASE && st_ff.page == sid_pkg::PAGE_ID) begin
            if (byte_idx == sid_pkg::EXT_ID_ADDR) begin
                rd_byte = EXT_ID_B;
            end else if (byte_idx == sid_pkg::CONNECTOR_ADDR) begin
                rd_byte = CONNECTOR;
            end else if (byte_idx >= sid_pkg::COMPLY_ADDR && byte_idx <= sid_pkg::COMPLY_LAST) begin
                off = 4'(byte_idx - sid_pkg::COMPLY_ADDR);
                rd_byte = COMPLIANCE[8 * (7 - off) +: 8];
            end else if (byte_idx == sid_pkg::ENCODING_ADDR) begin
                rd_byte = ENCODING;
            end else if (byte_idx == sid_pkg::RATE100_ADDR) begin
                rd_byte = RATE100_B;
            end else if (byte_idx == sid_pkg::RATESEL_ADDR) begin
                rd_byte = RATE_SEL_TAGS & sid_pkg::RATESEL_MASK;
            end else if (byte_idx == sid_pkg::SM_LEN_ADDR) begin
                rd_byte = sm_b;
            end else if (byte_idx == sid_pkg::OM3_LEN_ADDR) begin
                rd_byte = om3_b;
            end else if (byte_idx == sid_pkg::OM2_LEN_ADDR) begin
                rd_byte = om2_b;
            end else if (byte_idx == sid_pkg::OM1_LEN_ADDR) begin
                rd_byte = om1_b;
            end else if (byte_idx == sid_pkg::CABLE_LEN_ADDR) begin
                rd_byte = comb_b;
            end else if (byte_idx == sid_pkg::DEV_TECH_ADDR) begin
                rd_byte = {TX_TECH, TECH_FLAGS};
            end else if (byte_idx >= sid_pkg::VNAME_ADDR && byte_idx <= sid_pkg::VNAME_LAST) begin
                off = 4'(byte_idx - sid_pkg::VNAME_ADDR);
                rd_byte = VENDOR_NAME[8 * (15 - off) +: 8];
            end else if (byte_idx == sid_pkg::IRATE_ADDR) begin
                rd_byte = RATE_GEN_FLAGS & sid_pkg::IRATE_MASK;
            end else if (byte_idx >= sid_pkg::VCID_ADDR && byte_idx <= sid_pkg::VCID_LAST) begin
                off = 4'(byte_idx - sid_pkg::VCID_ADDR);
                rd_byte = VENDOR_CID[8 * (2 - off) +: 8];
            end else if (byte_idx >= sid_pkg::VPART_ADDR && byte_idx <= sid_pkg::VPART_LAST) begin
                off = 4'(byte_idx - sid_pkg::VPART_ADDR);
                rd_byte = VENDOR_PART[8 * (15 - off) +: 8];
            end else if (byte_idx == sid_pkg::RATE250_ADDR) begin
                rd_byte = RATE250_B;
            end
        end
    end

    // No wait states: answer registered at the edge ending setup, access completes at the next edge
    always_comb begin
        nxt_st = st_ff;
        nxt_st.ready = 1'b0;
        nxt_st.err = 1'b0;
        if (psel && !penable) begin
            nxt_st.ready = 1'b1;
            // Out-of-span or unaligned accesses complete with an error flag
            nxt_st.err = !in_span;
            nxt_st.rdata = {24'h00_0000, rd_byte};
            if (pwrite) begin
                nxt_st.rdata = sid_pkg::RDATA_RST;
            end
        end
        // Write lands only at the edge that completes the access
        if (psel && penable && st_ff.ready && !st_ff.err && pwrite) begin
            // Only the page select byte accepts writes; id bytes ignore them
            if (byte_idx == sid_pkg::PAGE_SEL_ADDR && pstrb[0]) begin
                nxt_st.page = pwdata[7:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '{page: sid_pkg::PAGE_ID, rdata: sid_pkg::RDATA_RST, ready: 1'b0, err: 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign prdata = st_ff.rdata;
    assign pready = st_ff.ready;
    assign pslverr = st_ff.err;
endmodule // sid_id_map

// [sid_pkg.sv]
// Package: serial identification page map constants and field layouts
package sid_pkg;
    // Byte addresses within the 256-byte management space
    localparam logic [7:0] PAGE_SEL_ADDR = 8'h7f;
    localparam logic [7:0] PAGE_ID = 8'h00;
    localparam logic [7:0] EXT_ID_ADDR = 8'h81;
    localparam logic [7:0] CONNECTOR_ADDR = 8'h82;
    localparam logic [7:0] COMPLY_ADDR = 8'h83;
    localparam logic [7:0] COMPLY_LAST = 8'h8a;
    localparam logic [7:0] ENCODING_ADDR = 8'h8b;
    localparam logic [7:0] RATE100_ADDR = 8'h8c;
    localparam logic [7:0] RATESEL_ADDR = 8'h8d;
    localparam logic [7:0] SM_LEN_ADDR = 8'h8e;
    localparam logic [7:0] OM3_LEN_ADDR = 8'h8f;
    localparam logic [7:0] OM2_LEN_ADDR = 8'h90;
    localparam logic [7:0] OM1_LEN_ADDR = 8'h91;
    localparam logic [7:0] CABLE_LEN_ADDR = 8'h92;
    localparam logic [7:0] DEV_TECH_ADDR = 8'h93;
    localparam logic [7:0] VNAME_ADDR = 8'h94;
    localparam logic [7:0] VNAME_LAST = 8'ha3;
    localparam logic [7:0] IRATE_ADDR = 8'ha4;
    localparam logic [7:0] VCID_ADDR = 8'ha5;
    localparam logic [7:0] VCID_LAST = 8'ha7;
    localparam logic [7:0] VPART_ADDR = 8'ha8;
    localparam logic [7:0] VPART_LAST = 8'hb7;
    localparam logic [7:0] RATE250_ADDR = 8'hde;
    localparam logic [7:0] UPPER_BASE = 8'h80;
    // APB word offsets (byte address = 4 * byte index)
    localparam logic [11:0] APB_SPAN = 12'h0400;
    // Field positions
    localparam int POWER_LSB = 0;
    localparam int RX_CDR_BIT = 2;
    localparam int TX_CDR_BIT = 3;
    localparam int CATALOG_BIT = 4;
    localparam int TX_TECH_LSB = 4;
    // Codes and saturations
    localparam logic [7:0] RATE_ESCAPE = 8'hff;
    localparam logic [7:0] LEN_SAT = 8'hff;
    localparam logic [7:0] LEN_MIN_CABLE = 8'h01;
    localparam logic [7:0] ASCII_SPACE = 8'h20;
    localparam logic [7:0] CONN_NONE_SEP = 8'h23;
    localparam logic [3:0] TECH_VCSEL850 = 4'h0;
    localparam logic [3:0] TECH_COPPER_LO = 4'ha;
    localparam logic [7:0] RATESEL_MASK = 8'h01;
    localparam logic [7:0] IRATE_MASK = 8'h1f;
    localparam logic [7:0] EXT_ID_MASK = 8'hdf;
    // Reach limits in metres; read data reset value
    localparam int VCSEL_MAX_M = 508;
    localparam int CABLE_MAX_M = 254;
    localparam logic [31:0] RDATA_RST = 32'h0000_0000;
endpackage

// [sid_field_fmt.sv]
// Fixed-field formatter: turns a raw reach figure into its length byte
`timescale 1ns/1ps
module sid_field_fmt #(
    parameter int STEP_M = 1,
    parameter int MAX_M = 254,
    parameter bit FLOOR_ONE = 1'b0
) (
    // Raw figure
    input wire logic [15:0] reach_m,
    input wire logic is_cable,
    // Encoded byte
    output logic [7:0] code
);
    initial begin
        if (STEP_M < 1 || MAX_M < STEP_M)
            $error("sid_field_fmt: bad step or limit");
    end
    logic [15:0] units;
    always_comb begin
        units = reach_m / 16'(STEP_M);
        if (is_cable) begin
            code = 8'h00;
        end else if (reach_m == 16'h0000) begin
            code = 8'h00;
        end else if (reach_m > 16'(MAX_M)) begin
            code = sid_pkg::LEN_SAT;
        end else if (FLOOR_ONE && units == 16'h0000) begin
            code = sid_pkg::LEN_MIN_CABLE;
        end else begin
            code = units[7:0];
        end
    end
endmodule // sid_field_fmt

// [sid_props.sv]
// Checker: bus timing and fixed-field properties of the identification map
`timescale 1ns/1ps
module sid_props (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    logic [7:0] page_ff;
    logic rd_ok;
    assign rd_ok = pready && !pwrite && !pslverr;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Shadow page byte, so hidden reads can be judged from the ports alone
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            page_ff <= 8'h00;
        end else if (pready && pwrite && !pslverr && paddr == 12'h1fc && pstrb[0]) begin
            page_ff <= pwdata[7:0];
        end
    end
    chk_ready_follows: assert property (psel && !penable |=> pready && penable)
        else $error("pready missing after setup");
    chk_ready_single: assert property (pready |=> !pready)
        else $error("pready held too long");
    chk_ready_access: assert property (pready |-> psel && penable)
        else $error("pready outside access phase");
    chk_err_span: assert property (psel && !penable && paddr[11:10] != 2'b00 |=> pslverr)
        else $error("no error for out of span address");
    chk_upper_zero: assert property (rd_ok |-> prdata[31:8] == 24'h00_0000)
        else $error("upper read data bits not zero");
    chk_rdata_hold: assert property (!psel |=> $stable(prdata))
        else $error("read data changed while idle");
    chk_ext_rsvd: assert property (rd_ok && paddr == 12'h204 |-> !prdata[5])
        else $error("reserved identifier bit set");
    chk_rsel_rsvd: assert property (rd_ok && paddr == 12'h234 |-> prdata[7:1] == 7'h00)
        else $error("reserved rate select bits set");
    chk_irate_rsvd: assert property (rd_ok && paddr == 12'h290 |-> prdata[7:5] == 3'h0)
        else $error("reserved rate code bits set");
    chk_page_hide: assert property (rd_ok && paddr[9] && page_ff != 8'h00 |-> prdata == 0)
        else $error("page shown while another page selected");
    chk_page_back: assert property (rd_ok && paddr == 12'h1fc |-> prdata[7:0] == page_ff)
        else $error("page byte reads back wrong");
    cov_conn_read: cover property (rd_ok && paddr == 12'h208);
    cov_error: cover property (pready && pslverr);
    cov_hidden: cover property (rd_ok && paddr[9] && page_ff != 8'h00);
endmodule // sid_props

// [sid_host_model.sv]
// Host model: APB master reading the identification page
`timescale 1ns/1ps
module sid_host_model (
    // Clock
    input wire logic pclk,
    // APB master
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    output logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        pstrb = 4'h0;
    end
    // Idle edge first, so back-to-back calls never drive a line twice at once
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
            output logic [31:0] rd, output logic err, output bit hung);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= 4'hf;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        hung = (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Released address and data lines show no stale value; pwrite and pstrb keep theirs
        paddr <= ~a;
        pwdata <= ~d;
    endtask
    function automatic int rate_mbps(input logic [7:0] b100, input logic [7:0] b250);
        return (b100 == 8'hff) ? int'(b250) * 250 : int'(b100) * 100;
    endfunction
endmodule // sid_host_model

// [tb.sv]
// Testbench: sweeps, write guards, paging and reset of the identification map
`timescale 1ns/1ps
module tb;
    localparam logic [63:0] COMP = 64'h0102_0000_0000_0080;
    localparam logic [127:0] VNAME = "SAMPLE MAKER    ";
    localparam logic [127:0] VPART = "XCVR-42         ";
    localparam logic [23:0] VCID = 24'h12_3456; // Arbitrary value
    localparam int RATE = 25750;
    localparam logic [1:0] PWR = 2'b11;
    localparam bit TXC = 1'b1;
    localparam bit RXC = 1'b0;
    localparam bit CAT = 1'b1;
    localparam logic [7:0] CONN = 8'h23;
    localparam logic [7:0] ENC = 8'h06;
    localparam logic [7:0] RSEL = 8'hff;
    localparam int SM_KM = 0;
    localparam int OM3_M = 300;
    localparam int OM2_M = 82;
    localparam int OM1_M = 33;
    localparam int COMB_M = 600;
    localparam logic [3:0] TECH = 4'h0;
    localparam logic [3:0] FLAGS = 4'hb;
    localparam logic [7:0] RGEN = 8'hff;
    // Copper cable variant
    localparam int RATE2 = 10300;
    localparam int CAB_M = 200;
    localparam logic [3:0] TECH2 = 4'hb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic psel2, penable2, pwrite2, pready2, pslverr2;
    logic [11:0] paddr2;
    logic [31:0] pwdata2, prdata2;
    logic [3:0] pstrb2;
    bit use_cu = 1'b0;
    int fails = 0;
    int checks = 0;
    int seed = 32'h0000_aea7;
    int page = 0;
    always #10 pclk = ~pclk;
    sid_id_map #(.POWER_CLASS(PWR), .TX_CDR(TXC), .RX_CDR(RXC), .CATALOG_PRESENT(CAT),
        .CONNECTOR(CONN), .COMPLIANCE(COMP), .ENCODING(ENC), .RATE_MBPS(RATE),
        .RATE_SEL_TAGS(RSEL), .SM_REACH_KM(SM_KM), .OM3_REACH_M(OM3_M), .OM2_REACH_M(OM2_M),
        .OM1_REACH_M(OM1_M), .COMBINED_REACH_M(COMB_M), .TX_TECH(TECH), .TECH_FLAGS(FLAGS),
        .VENDOR_NAME(VNAME), .VENDOR_CID(VCID), .VENDOR_PART(VPART), .RATE_GEN_FLAGS(RGEN))
    u_sid_id_map (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    sid_host_model u_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));
    // Copper cable: fibre bytes forced to zero, 1 m steps, rate below the escape
    sid_id_map #(.RATE_MBPS(RATE2), .OM3_REACH_M(OM3_M), .COMBINED_REACH_M(CAB_M),
        .TX_TECH(TECH2))
    u_sid_id_map_cu (.pclk(pclk), .presetn(presetn), .psel(psel2), .penable(penable2),
        .pwrite(pwrite2), .paddr(paddr2), .pwdata(pwdata2), .pstrb(pstrb2), .prdata(prdata2),
        .pready(pready2), .pslverr(pslverr2));
    sid_host_model u_host_cu (.pclk(pclk), .psel(psel2), .penable(penable2), .pwrite(pwrite2),
        .paddr(paddr2), .pwdata(pwdata2), .pstrb(pstrb2), .prdata(prdata2), .pready(pready2),
        .pslverr(pslverr2));
    function automatic int exp_cu(input int idx);
        case (idx)
            8'h8c: return RATE2 / 100;
            8'h8f: return 0;
            8'h92: return (CAB_M > 254) ? 255 : CAB_M;
            8'h93: return {TECH2, 4'h0};
            8'hde: return RATE2 / 250;
            default: return 0;
        endcase
    endfunction
    function automatic int exp_byte(input int idx);
        logic [127:0] t;
        t = 128'h0;
        if (idx == 8'h7f) return page;
        if (idx < 8'h80 || page != 0) return 0;
        if (idx >= 8'h83 && idx <= 8'h8a) return int'(8'(COMP >> (8 * (8'h8a - idx))));
        if (idx >= 8'h94 && idx <= 8'ha3) t = VNAME >> (8 * (8'ha3 - idx));
        if (idx >= 8'ha5 && idx <= 8'ha7) t = 128'(VCID) >> (8 * (8'ha7 - idx));
        if (idx >= 8'ha8 && idx <= 8'hb7) t = VPART >> (8 * (8'hb7 - idx));
        case (idx)
            8'h81: return {3'b000, CAT, TXC, RXC, PWR};
            8'h82: return CONN;
            8'h8b: return ENC;
            8'h8c: return (RATE > 25400) ? 8'hff : RATE / 100;
            8'h8d: return RSEL & 8'h01;
            8'h8e: return SM_KM;
            8'h8f: return OM3_M / 2;
            8'h90: return OM2_M;
            8'h91: return OM1_M;
            8'h92: return (COMB_M > 508) ? 255 : COMB_M / 2;
            8'h93: return {TECH, FLAGS};
            8'ha4: return RGEN & 8'h1f;
            8'hde: return RATE / 250;
            default: return int'(t[7:0]);
        endcase
    endfunction
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("FAIL %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        if (fails == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic acc(input logic wr, input logic [11:0] a, input logic [31:0] d, input int ed,
            input logic ee, output logic [31:0] rd);
        logic er;
        bit hung;
        if (use_cu) u_host_cu.xfer(wr, a, d, rd, er, hung);
        else u_host.xfer(wr, a, d, rd, er, hung);
        if (hung) begin
            fails++;
            end_sim();
        end else begin
            if (!wr && !ee) cmp(rd, 32'(ed));
            cmp({31'h0, er}, {31'h0, ee});
        end
    endtask
    initial begin
        int idx;
        logic [31:0] d, r1;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        for (idx = 8'h7f; idx <= 8'hff; idx++) acc(0, 12'(idx * 4), 0, exp_byte(idx), 0, d);
        acc(0, 12'h230, 0, exp_byte(8'h8c), 0, r1);
        acc(0, 12'h378, 0, exp_byte(8'hde), 0, d);
        cmp(32'(u_host.rate_mbps(r1[7:0], d[7:0])), 32'(RATE));
        repeat (24) begin
            idx = 8'h80 + ($random(seed) & 8'h7f);
            acc(1, 12'(idx * 4), $random(seed), 0, 0, d);
            acc(0, 12'(idx * 4), 0, exp_byte(idx), 0, d);
        end
        for (int p = 3; p >= 0; p -= 3) begin
            acc(1, 12'h1fc, 32'(p), 0, 0, d);
            page = p;
            acc(0, 12'h1fc, 0, exp_byte(8'h7f), 0, d);
            acc(0, 12'h208, 0, exp_byte(8'h82), 0, d);
        end
        acc(0, 12'h400, 0, 0, 1, d);
        acc(0, 12'h209, 0, 0, 1, d);
        acc(1, 12'h1fc, 32'h0000_0002, 0, 0, d);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        page = 0;
        acc(0, 12'h1fc, 0, exp_byte(8'h7f), 0, d);
        acc(0, 12'h204, 0, exp_byte(8'h81), 0, d);
        use_cu = 1'b1;
        for (idx = 8'h8e; idx <= 8'h93; idx++) acc(0, 12'(idx * 4), 0, exp_cu(idx), 0, d);
        acc(0, 12'h230, 0, exp_cu(8'h8c), 0, r1);
        acc(0, 12'h378, 0, exp_cu(8'hde), 0, d);
        cmp(32'(u_host.rate_mbps(r1[7:0], d[7:0])), 32'(RATE2));
        end_sim();
    end
endmodule // tb
bind sid_id_map sid_props u_sid_props (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
